// [pkg/wsi_pkg.sv]
// Shared constants and types for the wake, status and interrupt block.
`default_nettype none
package wsi_pkg;
  // Register indices on the serial register port.
  localparam logic [4:0] ADDR_RATE_LIMIT  = 5'h05;
  localparam logic [4:0] ADDR_STATUS      = 5'h08;
  // Rate and limit register: range 2 and limit 28 after reset.
  localparam logic [7:0] RATE_LIMIT_RESET = 8'h9c;
  localparam int         RATE_MSB         = 7;
  localparam int         RATE_LSB         = 6;
  localparam int         LIMIT_MSB        = 5;
  localparam int         LIMIT_LSB        = 0;
  // Lowest limit value that the host may program.
  localparam logic [5:0] LIMIT_MAX_MIN    = 6'h0c;
  // Extended period in data clock periods for each rate code.
  localparam logic [3:0] RATE_DIV_0       = 4'h8;
  localparam logic [3:0] RATE_DIV_1       = 4'h4;
  localparam logic [3:0] RATE_DIV_2       = 4'h2;
  localparam logic [3:0] RATE_DIV_3       = 4'h1;
  // Status register layout.
  localparam int         KEY_MSB          = 7;
  localparam int         KEY_LSB          = 3;
  localparam int         POWER_BIT        = 2;
  localparam int         LOW_BATT_BIT     = 1;
  localparam int         AUX_BIT          = 0;
  localparam logic [4:0] KEY_STATE_RESET  = 5'h00;
  localparam int         NUM_KEYS         = 5;
  // Debounce length in data clock periods.
  localparam int         DEBOUNCE_TICKS   = 8195;
  // Cycles after reset before pin levels are trusted.
  localparam logic [1:0] WAKE_SETTLE      = 2'h3;
  typedef enum logic [1:0] {
    DEB_IDLE = 2'b01,
    DEB_RUN  = 2'b10
  } wsi_deb_state_type;
endpackage
`default_nettype wire

// [src/wsi_sync2.sv]
// Two flip-flop synchroniser for a group of pin levels.
`default_nettype none
module wsi_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] init,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_ff;

  // The init value is a constant at each instance.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= init;
      q       <= init;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [src/wsi_limit_timer.sv]
// Extended data clock divider and maximum limit timer.
`default_nettype none
module wsi_limit_timer (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       dclk_tick,
  input  wire logic [1:0] rate_range,
  input  wire logic       limit_extension_bit,
  input  wire logic [5:0] limit_max,
  input  wire logic       limit_start,
  output logic            xdclk_tick,
  output logic            limit_expired
);
  logic [3:0] base_div;
  logic [4:0] period;
  logic [4:0] div_ff;
  logic [5:0] lim_cnt_ff;
  logic       run_ff;

  always_comb begin
    unique case (rate_range)
      2'h0:    base_div = wsi_pkg::RATE_DIV_0;
      2'h1:    base_div = wsi_pkg::RATE_DIV_1;
      2'h2:    base_div = wsi_pkg::RATE_DIV_2;
      default: base_div = wsi_pkg::RATE_DIV_3;
    endcase
    // Factor of two doubles the period.
    period = limit_extension_bit ? {base_div, 1'b0} : {1'b0, base_div};
  end

  assign xdclk_tick = dclk_tick && (div_ff == period - 5'h01) &&
                      !limit_start;

  // A start realigns the divider so the limit counts whole periods.
  always_ff @(posedge clk) begin
    if (reset || limit_start) begin
      div_ff <= 5'h00;
    end else if (dclk_tick) begin
      div_ff <= xdclk_tick ? 5'h00 : div_ff + 5'h01;
    end
  end

  // Limit time is (limit_max - 1) extended periods.
  always_ff @(posedge clk) begin
    if (reset) begin
      lim_cnt_ff    <= 6'h00;
      run_ff        <= 1'b0;
      limit_expired <= 1'b0;
    end else if (limit_start) begin
      lim_cnt_ff    <= 6'h00;
      run_ff        <= 1'b1;
      limit_expired <= 1'b0;
    end else if (run_ff && xdclk_tick) begin
      lim_cnt_ff <= lim_cnt_ff + 6'h01;
      if (lim_cnt_ff + 6'h01 == limit_max - 6'h01) begin
        run_ff        <= 1'b0;
        limit_expired <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [src/wsi_status_irq.sv]
// Status, wake-up, debounce and interrupt logic of the transceiver.
//
// Contract
// - Rate code selects period 8, 4, 2, 1
// - Limit time is limit minus one periods
// - Status register readable at address eight
// - Power or aux flag set or key update raises interrupt
// - Status read clears power and aux flags and interrupt
// - Key state bit is inverted pin level
// - Key wake sets key bit and interrupt
// - Key event starts debounce, 8195 ticks finish
// - Same key again stops debounce silently
// - Other key restarts debounce from zero
// - Running debounce forces supply and clock on
// - Status read or delete command clears interrupt
// - Power pin rising edge sets power flag
// - Power flag forces supply and clock on
// - Power pin low never enters off mode
// - Low battery clears on recovery plus read
// - Aux rising edge sets aux flag once
// - Aux wake sets aux flag and interrupt
// - Extension bit doubles the extended period
`default_nettype none
module wsi_status_irq #(
  parameter int DEBOUNCE_TICKS = wsi_pkg::DEBOUNCE_TICKS
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       DCLK_TICK,
  input  wire logic       ACTIVE_MODE,
  input  wire logic       LIMIT_EXTENSION_BIT,
  input  wire logic       LIMIT_START,
  input  wire logic [4:0] KEY_INPUT_PIN,
  input  wire logic       POWER_WAKE_PIN,
  input  wire logic       AUX_SUPPLY_PIN,
  input  wire logic       SUPPLY_LOW,
  input  wire logic       SUPPLY_RECOVERED,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [4:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       DELETE_IRQ,
  output logic      [7:0] REG_RDATA,
  output logic            IRQ,
  output logic            EXT_SUPPLY_ENABLE_FORCE,
  output logic            CLK_OUT_ENABLE_FORCE,
  output logic            XDCLK_TICK,
  output logic            LIMIT_EXPIRED,
  output logic      [1:0] RATE_RANGE,
  output logic      [5:0] LIMIT_MAX
);
  localparam logic [13:0] DEB_LAST = 14'(DEBOUNCE_TICKS - 1);

  logic [4:0] key_sync;
  logic       power_sync;
  logic       aux_sync;
  logic       low_sync;
  logic       recov_sync;
  logic [4:0] key_prev_ff;
  logic       power_prev_ff;
  logic       aux_prev_ff;
  logic [1:0] settle_ff;
  logic       ready_ff;
  logic       wake_now;
  logic [4:0] key_evt;
  logic       power_rise;
  logic       aux_rise;
  logic       status_rd;
  logic       irq_clear;
  logic [7:0] rate_limit_ff;
  logic [4:0] key_state_ff;
  logic       power_on_ff;
  logic       low_batt_ff;
  logic       aux_on_ff;
  logic       irq_ff;
  logic [7:0] status_value;
  logic       power_set;
  logic       aux_set;
  logic       deb_done;
  logic       key_wake;
  wsi_pkg::wsi_deb_state_type deb_state_ff;
  wsi_pkg::wsi_deb_state_type nxt_deb_state;
  logic [13:0] deb_cnt_ff;
  logic [13:0] nxt_deb_cnt;
  logic [2:0]  deb_key_ff;
  logic [2:0]  nxt_deb_key;
  logic [2:0]  evt_index;

  // Key pins idle high through their pull-ups.
  wsi_sync2 #(.WIDTH(5)) u_key_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     (KEY_INPUT_PIN),
    .init  (5'h1f),
    .q     (key_sync)
  );

  wsi_sync2 #(.WIDTH(4)) u_misc_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     ({POWER_WAKE_PIN, AUX_SUPPLY_PIN, SUPPLY_LOW,
             SUPPLY_RECOVERED}),
    .init  (4'h0),
    .q     ({power_sync, aux_sync, low_sync, recov_sync})
  );

  wsi_limit_timer u_limit (
    .clk                 (CLK),
    .reset               (RESET),
    .dclk_tick           (DCLK_TICK),
    .rate_range          (RATE_RANGE),
    .limit_extension_bit (LIMIT_EXTENSION_BIT),
    .limit_max           (LIMIT_MAX),
    .limit_start         (LIMIT_START),
    .xdclk_tick          (XDCLK_TICK),
    .limit_expired       (LIMIT_EXPIRED)
  );

  // Pin levels are trusted only once the synchronisers hold real
  // samples; the first trusted cycle is the wake-up capture.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      settle_ff <= 2'h0;
      ready_ff  <= 1'b0;
    end else if (settle_ff != wsi_pkg::WAKE_SETTLE) begin
      settle_ff <= settle_ff + 2'h1;
    end else begin
      ready_ff <= 1'b1;
    end
  end

  assign wake_now = (settle_ff == wsi_pkg::WAKE_SETTLE) && !ready_ff;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      key_prev_ff   <= 5'h1f;
      power_prev_ff <= 1'b0;
      aux_prev_ff   <= 1'b0;
    end else begin
      key_prev_ff   <= key_sync;
      power_prev_ff <= power_sync;
      aux_prev_ff   <= aux_sync;
    end
  end

  // Power and aux count rising edges only, keys count either edge; a falling power pin does nothing here.
  assign key_evt    = (ready_ff && ACTIVE_MODE) ?
                      (key_sync ^ key_prev_ff) : 5'h00;
  assign power_rise = ready_ff && ACTIVE_MODE &&
                      power_sync && !power_prev_ff;
  assign aux_rise   = ready_ff && ACTIVE_MODE &&
                      aux_sync && !aux_prev_ff;
  assign key_wake   = wake_now && (key_sync != 5'h1f);

  assign status_rd = REG_RD && (REG_ADDR == wsi_pkg::ADDR_STATUS);
  assign irq_clear = status_rd || DELETE_IRQ;

  // Register writes; the status address takes no writes.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rate_limit_ff <= wsi_pkg::RATE_LIMIT_RESET;
    end else if (REG_WR &&
                 REG_ADDR == wsi_pkg::ADDR_RATE_LIMIT) begin
      rate_limit_ff <= REG_WDATA;
    end
  end

  assign RATE_RANGE = rate_limit_ff[wsi_pkg::RATE_MSB:wsi_pkg::RATE_LSB];
  assign LIMIT_MAX  = rate_limit_ff[wsi_pkg::LIMIT_MSB:wsi_pkg::LIMIT_LSB];

  // Lowest numbered key wins when several change together.
  always_comb begin
    evt_index = 3'h0;
    for (int i = wsi_pkg::NUM_KEYS - 1; i >= 0; i--) begin
      if (key_evt[i]) begin
        evt_index = 3'(i);
      end
    end
  end

  assign deb_done = (deb_state_ff == wsi_pkg::DEB_RUN) && DCLK_TICK &&
                    (deb_cnt_ff == DEB_LAST) && (key_evt == 5'h00);

  always_comb begin
    nxt_deb_state = deb_state_ff;
    nxt_deb_cnt   = deb_cnt_ff;
    nxt_deb_key   = deb_key_ff;
    unique case (deb_state_ff)
      wsi_pkg::DEB_IDLE: begin
        if (key_evt != 5'h00) begin
          nxt_deb_state = wsi_pkg::DEB_RUN;
          nxt_deb_cnt   = 14'h0000;
          nxt_deb_key   = evt_index;
        end
      end
      wsi_pkg::DEB_RUN: begin
        if (key_evt[deb_key_ff]) begin
          nxt_deb_state = wsi_pkg::DEB_IDLE;
        end else if (key_evt != 5'h00) begin
          nxt_deb_cnt = 14'h0000;
          nxt_deb_key = evt_index;
        end else if (deb_done) begin
          nxt_deb_state = wsi_pkg::DEB_IDLE;
        end else if (DCLK_TICK) begin
          nxt_deb_cnt = deb_cnt_ff + 14'h0001;
        end
      end
      default: begin
        nxt_deb_state = wsi_pkg::DEB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      deb_state_ff <= wsi_pkg::DEB_IDLE;
      deb_cnt_ff   <= 14'h0000;
      deb_key_ff   <= 3'h0;
    end else begin
      deb_state_ff <= nxt_deb_state;
      deb_cnt_ff   <= nxt_deb_cnt;
      deb_key_ff   <= nxt_deb_key;
    end
  end

  // All key bits take the inverted pin levels at each update.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      key_state_ff <= wsi_pkg::KEY_STATE_RESET;
    end else if (deb_done || key_wake) begin
      key_state_ff <= ~key_sync;
    end
  end

  assign power_set = power_rise || (wake_now && power_sync);
  assign aux_set   = aux_rise || (wake_now && aux_sync);

  // A set in the same cycle as a read wins over the clear.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      power_on_ff <= 1'b0;
    end else if (power_set) begin
      power_on_ff <= 1'b1;
    end else if (status_rd) begin
      power_on_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aux_on_ff <= 1'b0;
    end else if (aux_set) begin
      aux_on_ff <= 1'b1;
    end else if (status_rd) begin
      aux_on_ff <= 1'b0;
    end
  end

  // Low battery needs both recovery and a read to clear.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      low_batt_ff <= 1'b0;
    end else if (low_sync) begin
      low_batt_ff <= 1'b1;
    end else if (status_rd && recov_sync) begin
      low_batt_ff <= 1'b0;
    end
  end

  // Flags already set give no new interrupt.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_ff <= 1'b0;
    end else if ((power_set && !power_on_ff) ||
                 (aux_set && !aux_on_ff) ||
                 deb_done || key_wake) begin
      irq_ff <= 1'b1;
    end else if (irq_clear) begin
      irq_ff <= 1'b0;
    end
  end

  assign IRQ = irq_ff;

  assign status_value = {key_state_ff, power_on_ff, low_batt_ff,
                         aux_on_ff};

  // Read data stand until the next read.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        wsi_pkg::ADDR_STATUS:     REG_RDATA <= status_value;
        wsi_pkg::ADDR_RATE_LIMIT: REG_RDATA <= rate_limit_ff;
        default:                  REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Forces keep the supply and clock on while software is busy.
  assign EXT_SUPPLY_ENABLE_FORCE = power_on_ff ||
         (deb_state_ff == wsi_pkg::DEB_RUN);
  assign CLK_OUT_ENABLE_FORCE    = power_on_ff ||
         (deb_state_ff == wsi_pkg::DEB_RUN);
endmodule
`default_nettype wire

// [tb/wsi_status_irq_assertions.sv]
// Checker for the wake, status and interrupt block ports.
`default_nettype none
module wsi_status_irq_checker (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       DCLK_TICK,
  input wire logic       LIMIT_START,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [4:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       DELETE_IRQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic       IRQ,
  input wire logic       EXT_SUPPLY_ENABLE_FORCE,
  input wire logic       CLK_OUT_ENABLE_FORCE,
  input wire logic       XDCLK_TICK,
  input wire logic       LIMIT_EXPIRED,
  input wire logic [1:0] RATE_RANGE,
  input wire logic [5:0] LIMIT_MAX
);
  logic [7:0] wd_ff;
  always_ff @(posedge CLK) begin
    wd_ff <= REG_WDATA;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_force_pair: assert property (
    EXT_SUPPLY_ENABLE_FORCE == CLK_OUT_ENABLE_FORCE)
    else $error("supply and clock forces differ");
  a_rd_clears_irq: assert property (
    REG_RD && REG_ADDR == 5'h08 |=> !IRQ)
    else $error("status read left irq set");
  a_del_clears_irq: assert property (
    DELETE_IRQ |=> !IRQ) else $error("delete left irq set");
  a_irq_holds: assert property (
    IRQ && !REG_RD && !DELETE_IRQ |=> IRQ)
    else $error("irq dropped without clear");
  a_rdata_hold: assert property (
    !REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  a_wr_config: assert property (
    REG_WR && REG_ADDR == 5'h05 |=> {RATE_RANGE, LIMIT_MAX} == wd_ff)
    else $error("config write not taken");
  a_cfg_stable: assert property (
    !(REG_WR && REG_ADDR == 5'h05) |=> $stable({RATE_RANGE, LIMIT_MAX}))
    else $error("config changed without write");
  a_xtick_on_dtick: assert property (
    XDCLK_TICK |-> DCLK_TICK) else $error("extended tick off data tick");
  a_expired_hold: assert property (
    LIMIT_EXPIRED && !LIMIT_START |=> LIMIT_EXPIRED)
    else $error("expired dropped before start");
  a_start_clears: assert property (
    LIMIT_START |=> !LIMIT_EXPIRED) else $error("expired after start");
endmodule
bind wsi_status_irq wsi_status_irq_checker chk_i (
  .CLK(CLK), .RESET(RESET), .DCLK_TICK(DCLK_TICK),
  .LIMIT_START(LIMIT_START), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .DELETE_IRQ(DELETE_IRQ),
  .REG_RDATA(REG_RDATA), .IRQ(IRQ),
  .EXT_SUPPLY_ENABLE_FORCE(EXT_SUPPLY_ENABLE_FORCE),
  .CLK_OUT_ENABLE_FORCE(CLK_OUT_ENABLE_FORCE), .XDCLK_TICK(XDCLK_TICK),
  .LIMIT_EXPIRED(LIMIT_EXPIRED), .RATE_RANGE(RATE_RANGE),
  .LIMIT_MAX(LIMIT_MAX));
`default_nettype wire

// [tb/wsi_host_model.sv]
// Host controller model for the register port and delete command.
`default_nettype none
module wsi_host_model #(
  parameter bit ASK_MODE = 1'b0
) (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            delete_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // The model times nothing from the output clock, so a short first
  // cycle of that clock after wake-up cannot upset it.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    delete_irq = 1'b0;
  end
  // Idle bus lines flip so a stale value is never mistaken for a new one.
  task automatic gap();
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    if (a == wsi_pkg::ADDR_RATE_LIMIT && d[5:0] < wsi_pkg::LIMIT_MAX_MIN)
      d[5:0] = wsi_pkg::LIMIT_MAX_MIN;
    if (ASK_MODE && a == wsi_pkg::ADDR_RATE_LIMIT && d[7:6] == 2'h3)
      d[7:6] = 2'h2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    gap();
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
    gap();
  endtask
  task automatic del();
    delete_irq = 1'b1;
    @(negedge clk);
    delete_irq = 1'b0;
    gap();
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the wake, status and interrupt block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 20;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       ext = 1'b0;
  logic       start = 1'b0;
  logic [4:0] keys = 5'h1e;
  logic       pwr = 1'b1;
  logic       aux = 1'b0;
  logic       low = 1'b0;
  logic       rec = 1'b1;
  logic       act = 1'b1;
  logic       dt = 1'b1;
  logic       half = 1'b0;
  logic       wr, rd, del, irq, fe, fc, xt, ex;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [1:0] rr;
  logic [5:0] lm;
  int         err_count = 0;
  int         tests_run = 0;
  int         n, t0, t1, nt;
  always #20 clk = ~clk;
  // In half mode the data clock ticks every other cycle, which shows
  // that the divider counts ticks and not clock cycles.
  always @(negedge clk) dt <= half ? ~dt : 1'b1;
  wsi_host_model host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .delete_irq(del));
  wsi_status_irq #(.DEBOUNCE_TICKS(DEB)) uut (.CLK(clk), .RESET(reset),
    .DCLK_TICK(dt), .ACTIVE_MODE(act), .LIMIT_EXTENSION_BIT(ext),
    .LIMIT_START(start), .KEY_INPUT_PIN(keys), .POWER_WAKE_PIN(pwr),
    .AUX_SUPPLY_PIN(aux), .SUPPLY_LOW(low), .SUPPLY_RECOVERED(rec),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .DELETE_IRQ(del), .REG_RDATA(rdata), .IRQ(irq),
    .EXT_SUPPLY_ENABLE_FORCE(fe), .CLK_OUT_ENABLE_FORCE(fc),
    .XDCLK_TICK(xt), .LIMIT_EXPIRED(ex), .RATE_RANGE(rr), .LIMIT_MAX(lm));
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1) begin
      if (n == lim) begin
        err_count++;
        wrap_up();
      end
      n++;
      cyc(1);
    end
  endtask
  // Ticks are counted at the rising edge, where the design samples them.
  task automatic lim_run(input logic [7:0] span);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    nt = 0;
    n = 0;
    t0 = 0;
    t1 = 0;
    while (ex !== 1'b1) begin
      if (n == 2000) begin
        err_count++;
        wrap_up();
      end
      @(posedge clk);
      if (xt === 1'b1) begin
        nt++;
        if (nt == 1) t0 = n;
        if (nt == 2) t1 = n;
      end
      n++;
      @(negedge clk);
    end
    chk(8'(nt), 8'h0b);
    chk(8'(t1 - t0), span);
  endtask
  initial begin
    cyc(12);
    reset = 1'b0;
    cyc(6);
    chk({6'h0, irq, fe & fc}, 8'h03);
    rdc(5'h08, 8'h0c);
    chk({6'h0, irq, fe}, 8'h00);
    rdc(5'h08, 8'h08);
    rdc(5'h05, 8'h9c);
    host.wr(5'h08, 8'hf7);
    rdc(5'h08, 8'h08);
    rdc(5'h1f, 8'h00);
    pwr = 1'b0;
    keys = 5'h1f;
    cyc(4);
    chk({7'h0, fe}, 8'h01);
    wait_irq(DEB + 8);
    chk(8'(n), 8'(DEB - 1));
    rdc(5'h08, 8'h00);
    keys = 5'h1d;
    cyc(5);
    keys = 5'h1f;
    cyc(DEB + 10);
    chk({7'h0, irq}, 8'h00);
    rdc(5'h08, 8'h00);
    keys = 5'h1b;
    cyc(10);
    keys = 5'h13;
    cyc(DEB - 4);
    chk({7'h0, irq}, 8'h00);
    wait_irq(20);
    host.del();
    chk({7'h0, irq}, 8'h00);
    rdc(5'h08, 8'h60);
    aux = 1'b1;
    wait_irq(8);
    host.del();
    aux = 1'b0;
    cyc(4);
    aux = 1'b1;
    cyc(6);
    chk({7'h0, irq}, 8'h00);
    rdc(5'h08, 8'h61);
    rdc(5'h08, 8'h60);
    pwr = 1'b1;
    wait_irq(8);
    rdc(5'h08, 8'h64);
    rec = 1'b0;
    low = 1'b1;
    cyc(4);
    chk({7'h0, irq}, 8'h00);
    low = 1'b0;
    rdc(5'h08, 8'h62);
    rdc(5'h08, 8'h62);
    rec = 1'b1;
    cyc(4);
    rdc(5'h08, 8'h62);
    rdc(5'h08, 8'h60);
    for (int c = 0; c < 8; c++) begin
      ext = c[2];
      host.wr(5'h05, {c[1:0], 6'h0c});
      rdc(5'h05, {c[1:0], 6'h0c});
      chk({rr, lm}, {c[1:0], 6'h0c});
      lim_run(8'((8 >> c[1:0]) << c[2]));
    end
    ext = 1'b0;
    half = 1'b1;
    host.wr(5'h05, 8'h8c);
    lim_run(8'h04);
    half = 1'b0;
    keys = 5'h1f;
    pwr = 1'b0;
    reset = 1'b1;
    cyc(12);
    reset = 1'b0;
    cyc(6);
    chk({6'h0, irq, fe}, 8'h02);
    rdc(5'h08, 8'h01);
    chk({rr, lm}, wsi_pkg::RATE_LIMIT_RESET);
    act = 1'b0;
    pwr = 1'b1;
    cyc(6);
    chk({7'h0, irq}, 8'h00);
    rdc(5'h08, 8'h00);
    act = 1'b1;
    wrap_up();
  end
endmodule
`default_nettype wire
